// *** relative_branch_pkg.sv ***
// Summary of operation
// - unconditional branch loads pc with pc plus displacement and resumes there
// - relative base is the address of the word following the branch
// - displacement is a signed 32-bit two's complement value
// - unconditional branch takes short field, long extension word or address register
// - short 15-bit displacement is sign-extended before the add
// - neither branch touches condition, exception status or sticky exception bits
// - unconditional branch costs six cycles plus jump extra, one word plus extension
// - bit-test branch jumps to the relative target when the tested bit is zero
// - when the tested bit is one, pc advances to the next instruction
// - address register update from the addressing mode happens taken or not
// - bit-test branch always fetches a 32-bit displacement extension word
// - source may be memory-alterable, absolute short, short i/o or core register
// - effective address uses eight registers, indirect only, no long offset mode
// - testing the upper stack word pops the stack, stack pointer minus one
// - bit position is a 5-bit immediate field, 0 to 31
// - absolute short and short i/o forms carry a 7-bit address field
// - bit-test branch costs eight cycles plus jump extra, always two words
// - every memory-alterable mode except long-offset indirect may reach the bit-test source operand
package relative_branch_pkg;

  // one oscillator cycle is taken as one sys_clk period
  localparam logic [7:0]  UNC_BASE_CYCLES   = 8'h06;
  localparam logic [7:0]  BITC_BASE_CYCLES  = 8'h08;
  localparam logic [7:0]  JUMP_EXTRA_CYCLES = 8'h02;
  localparam logic [7:0]  UNC_TOTAL_CYCLES  = UNC_BASE_CYCLES + JUMP_EXTRA_CYCLES;
  localparam logic [7:0]  BITC_TOTAL_CYCLES = BITC_BASE_CYCLES + JUMP_EXTRA_CYCLES;
  localparam logic [1:0]  ONE_WORD  = 2'h1;
  localparam logic [1:0]  TWO_WORDS = 2'h2;

  // opcode patterns
  localparam logic [9:0]  UNC_SHORT_HI  = 10'h00e;
  localparam logic [6:0]  UNC_SHORT_LO  = 7'h7e;
  localparam logic [31:0] UNC_LONG_WORD = 32'h0300_3f00;
  localparam logic [14:0] UNC_REG_HI    = 15'h0181;
  localparam logic [13:0] UNC_REG_LO    = 14'h3f00;
  localparam logic [7:0]  BITC_TOP      = 8'h02;
  localparam logic [3:0]  BITC_GRP_EA   = 4'h8;
  localparam logic [3:0]  BITC_GRP_SH   = 4'ha;
  localparam logic [3:0]  BITC_GRP_REG  = 4'hb;
  localparam logic [2:0]  BITC_SUB      = 3'h2;
  localparam logic [2:0]  BIT_PAD       = 3'h0;

  // field positions
  localparam int SHORT_HI_MSB = 21;
  localparam int SHORT_HI_LSB = 14;
  localparam int SHORT_LO_MSB = 6;
  localparam int REG_SEL_MSB  = 16;
  localparam int REG_SEL_LSB  = 14;
  localparam int EA_MODE_MSB  = 19;
  localparam int EA_MODE_LSB  = 17;
  localparam int SHORT_AD_MSB = 18;
  localparam int SHORT_AD_LSB = 12;
  localparam int IO_SEL_BIT   = 19;
  localparam int CORE_REG_MSB = 19;
  localparam int CORE_REG_LSB = 13;
  localparam int SPACE_BIT    = 8;
  localparam int BITNUM_MSB   = 4;

  localparam logic [31:0] IO_SHORT_BASE = 32'hffff_ff80;
  localparam logic [6:0]  STACK_UPPER_CODE = 7'h7c;
  localparam logic        SPACE_FIRST  = 1'b0;
  localparam logic        SPACE_SECOND = 1'b1;

  // indirect address modes
  localparam logic [2:0] EA_POST_DEC_N = 3'h0;
  localparam logic [2:0] EA_POST_INC_N = 3'h1;
  localparam logic [2:0] EA_POST_DEC   = 3'h2;
  localparam logic [2:0] EA_POST_INC   = 3'h3;
  localparam logic [2:0] EA_PLAIN      = 3'h4;
  localparam logic [2:0] EA_INDEXED_N  = 3'h5;
  localparam logic [2:0] EA_LONG_OFS   = 3'h6;
  localparam logic [2:0] EA_PRE_DEC    = 3'h7;

  typedef enum logic [2:0] {
    K_NONE      = 3'b000,
    K_UNC_SHORT = 3'b001,
    K_UNC_LONG  = 3'b010,
    K_UNC_REG   = 3'b011,
    K_CLR_EA    = 3'b100,
    K_CLR_ABS   = 3'b101,
    K_CLR_IO    = 3'b110,
    K_CLR_REG   = 3'b111
  } branch_kind_t;

  typedef enum logic [1:0] {
    S_IDLE    = 2'b00,
    S_EXT     = 2'b01,
    S_OPERAND = 2'b10,
    S_RUN     = 2'b11
  } exec_state_t;

  function automatic logic [31:0] sext15(input logic [14:0] v);
    sext15 = {{17{v[14]}}, v};
  endfunction : sext15

  function automatic logic is_clr(input branch_kind_t k);
    is_clr = k[2];
  endfunction : is_clr

endpackage : relative_branch_pkg

// *** branch_opcode_decoder.sv ***
`timescale 1ns/1ps
module branch_opcode_decoder
(
  input  wire logic [31:0]                  opcode,
  output relative_branch_pkg::branch_kind_t kind,
  output logic [14:0]                       short_disp,
  output logic [2:0]                        reg_sel,
  output logic [2:0]                        ea_mode,
  output logic [6:0]                        short_addr,
  output logic [6:0]                        core_reg,
  output logic                              space_sel,
  output logic [4:0]                        bit_num
);
  import relative_branch_pkg::*;

  logic clr_common;

  always_comb
  begin
    short_disp = {opcode[SHORT_HI_MSB:SHORT_HI_LSB], opcode[SHORT_LO_MSB:0]};
    reg_sel    = opcode[REG_SEL_MSB:REG_SEL_LSB];
    ea_mode    = opcode[EA_MODE_MSB:EA_MODE_LSB];
    short_addr = opcode[SHORT_AD_MSB:SHORT_AD_LSB];
    core_reg   = opcode[CORE_REG_MSB:CORE_REG_LSB];
    space_sel  = opcode[SPACE_BIT];
    bit_num    = opcode[BITNUM_MSB:0];
    clr_common = (opcode[31:24] == BITC_TOP) && (opcode[11:9] == BITC_SUB)
                 && (opcode[7:5] == BIT_PAD);
    kind       = K_NONE;
    if ((opcode[31:22] == UNC_SHORT_HI) && (opcode[13:7] == UNC_SHORT_LO))
      kind = K_UNC_SHORT;
    else if (opcode == UNC_LONG_WORD)
      kind = K_UNC_LONG;
    else if ((opcode[31:17] == UNC_REG_HI) && (opcode[13:0] == UNC_REG_LO))
      kind = K_UNC_REG;
    else if (clr_common)
    begin
      case (opcode[23:20])
        // long-offset indirect has no room beside the displacement word
        BITC_GRP_EA:  kind = (opcode[13:12] == 2'h0 && ea_mode != EA_LONG_OFS) ? K_CLR_EA : K_NONE;
        BITC_GRP_SH:  kind = opcode[IO_SEL_BIT] ? K_CLR_IO : K_CLR_ABS;
        BITC_GRP_REG: kind = (opcode[12] == 1'b0 && opcode[SPACE_BIT] == 1'b0) ? K_CLR_REG : K_NONE;
        default:       kind = K_NONE;
      endcase
    end
  end

endmodule : branch_opcode_decoder

// *** branch_target_calc.sv ***
`timescale 1ns/1ps
module branch_target_calc
(
  input  relative_branch_pkg::branch_kind_t kind,
  input  wire logic [14:0]                  short_disp,
  input  wire logic [31:0]                  long_disp,
  input  wire logic [31:0]                  reg_disp,
  input  wire logic [31:0]                  pc_base,
  output logic [31:0]                       target
);
  import relative_branch_pkg::*;

  logic [31:0] disp;

  always_comb
  begin
    case (kind)
      K_UNC_SHORT: disp = sext15(short_disp);
      K_UNC_REG:   disp = reg_disp;
      default:     disp = long_disp;
    endcase
    // modulo 2^32 add is the same for signed and unsigned operands
    target = pc_base + disp;
  end

endmodule : branch_target_calc

// *** relative_branch_exec.sv ***
`timescale 1ns/1ps
module relative_branch_exec
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             instr_valid,
  input  wire logic [31:0]      instr_word,
  input  wire logic [31:0]      instr_pc,
  input  wire logic             ext_valid,
  input  wire logic [31:0]      ext_word,
  input  wire logic [7:0][31:0] addr_regs,
  input  wire logic [7:0][31:0] offset_regs,
  input  wire logic             operand_ack,
  input  wire logic [31:0]      operand_data,
  output logic                  busy,
  output logic                  illegal_instr,
  output logic                  ext_req,
  output logic                  operand_req,
  output logic                  operand_is_reg,
  output logic                  operand_space,
  output logic [31:0]           operand_addr,
  output logic [6:0]            operand_reg_code,
  output logic                  ar_write,
  output logic [2:0]            ar_index,
  output logic [31:0]           ar_value,
  output logic                  sp_decrement,
  output logic                  status_write,
  output logic                  pc_load,
  output logic [31:0]           pc_value,
  output logic                  branch_taken,
  output logic [7:0]            cycle_count,
  output logic [1:0]            word_count
);
  import relative_branch_pkg::*;

  logic         rst_meta;
  logic         rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  branch_kind_t dec_kind;
  logic [14:0]  dec_short;
  logic [2:0]   dec_reg;
  logic [2:0]   dec_mode;
  logic [6:0]   dec_addr;
  logic [6:0]   dec_core;
  logic         dec_space;
  logic [4:0]   dec_bit;

  branch_opcode_decoder u_decoder (
    .opcode     (instr_word),
    .kind       (dec_kind),
    .short_disp (dec_short),
    .reg_sel    (dec_reg),
    .ea_mode    (dec_mode),
    .short_addr (dec_addr),
    .core_reg   (dec_core),
    .space_sel  (dec_space),
    .bit_num    (dec_bit)
  );

  // returns {update, address, new register value}
  function automatic logic [64:0] ea_eval(input logic [2:0] mode, input logic [31:0] rn, input logic [31:0] nn);
    logic [31:0] addr;
    logic [31:0] upd;
    logic        wr;
    addr = rn;
    upd  = rn;
    wr   = 1'b1;
    case (mode)
      EA_POST_DEC_N: upd = rn - nn;
      EA_POST_INC_N: upd = rn + nn;
      EA_POST_DEC:   upd = rn - 32'h0000_0001;
      EA_POST_INC:   upd = rn + 32'h0000_0001;
      EA_INDEXED_N:
      begin
        addr = rn + nn;
        wr   = 1'b0;
      end
      EA_PRE_DEC:
      begin
        addr = rn - 32'h0000_0001;
        upd  = addr;
      end
      default:       wr = 1'b0;
    endcase
    ea_eval = {wr, addr, upd};
  endfunction : ea_eval

  exec_state_t  state;
  exec_state_t  next_state;
  branch_kind_t kind;
  branch_kind_t next_kind;
  logic [14:0]  short_disp;
  logic [14:0]  next_short_disp;
  logic [31:0]  disp;
  logic [31:0]  next_disp;
  logic [31:0]  pc_base;
  logic [31:0]  next_pc_base;
  logic [31:0]  reg_disp;
  logic [31:0]  next_reg_disp;
  logic [4:0]   bit_sel;
  logic [4:0]   next_bit_sel;
  logic         tested_bit;
  logic         next_tested_bit;
  logic         pend_upd;
  logic         next_pend_upd;
  logic [31:0]  pend_value;
  logic [31:0]  next_pend_value;
  logic         pend_pop;
  logic         next_pend_pop;
  logic [7:0]   cnt;
  logic [7:0]   next_cnt;
  logic [7:0]   total;
  logic [31:0]  target;
  logic [64:0]  ea_res;

  logic         next_busy;
  logic         next_illegal_instr;
  logic         next_ext_req;
  logic         next_operand_req;
  logic         next_operand_is_reg;
  logic         next_operand_space;
  logic [31:0]  next_operand_addr;
  logic [6:0]   next_operand_reg_code;
  logic         next_ar_write;
  logic [2:0]   next_ar_index;
  logic [31:0]  next_ar_value;
  logic         next_sp_decrement;
  logic         next_pc_load;
  logic [31:0]  next_pc_value;
  logic         next_branch_taken;
  logic [7:0]   next_cycle_count;
  logic [1:0]   next_word_count;

  branch_target_calc u_target (
    .kind       (kind),
    .short_disp (short_disp),
    .long_disp  (disp),
    .reg_disp   (reg_disp),
    .pc_base    (pc_base),
    .target     (target)
  );

  assign total  = is_clr(kind) ? BITC_TOTAL_CYCLES : UNC_TOTAL_CYCLES;
  assign ea_res = ea_eval(dec_mode, addr_regs[dec_reg], offset_regs[dec_reg]);

  always_comb
  begin
    next_state            = state;
    next_kind             = kind;
    next_short_disp       = short_disp;
    next_disp             = disp;
    next_pc_base          = pc_base;
    next_reg_disp         = reg_disp;
    next_bit_sel          = bit_sel;
    next_tested_bit       = tested_bit;
    next_pend_upd         = pend_upd;
    next_pend_value       = pend_value;
    next_pend_pop         = pend_pop;
    next_cnt              = (cnt == 8'hff) ? cnt : cnt + 8'h01;
    next_busy             = busy;
    next_illegal_instr    = 1'b0;
    next_ext_req          = 1'b0;
    next_operand_req      = 1'b0;
    next_operand_is_reg   = operand_is_reg;
    next_operand_space    = operand_space;
    next_operand_addr     = operand_addr;
    next_operand_reg_code = operand_reg_code;
    next_ar_write         = 1'b0;
    next_ar_index         = ar_index;
    next_ar_value         = ar_value;
    next_sp_decrement     = 1'b0;
    next_pc_load          = 1'b0;
    next_pc_value         = pc_value;
    next_branch_taken     = branch_taken;
    next_cycle_count      = cycle_count;
    next_word_count       = word_count;
    case (state)
      S_IDLE:
      begin
        if (instr_valid)
        begin
          if (dec_kind == K_NONE)
            next_illegal_instr = 1'b1;
          else
          begin
            next_kind       = dec_kind;
            next_short_disp = dec_short;
            next_reg_disp   = addr_regs[dec_reg];
            next_pc_base    = instr_pc + 32'h0000_0001;
            next_bit_sel    = dec_bit;
            next_cnt        = 8'h01;
            next_busy       = 1'b1;
            next_operand_is_reg   = (dec_kind == K_CLR_REG);
            next_operand_space    = dec_space;
            next_operand_reg_code = dec_core;
            next_ar_index         = dec_reg;
            next_pend_upd   = (dec_kind == K_CLR_EA) && ea_res[64];
            next_pend_value = ea_res[31:0];
            next_pend_pop   = (dec_kind == K_CLR_REG) && (dec_core == STACK_UPPER_CODE);
            case (dec_kind)
              K_CLR_EA:  next_operand_addr = ea_res[63:32];
              K_CLR_ABS: next_operand_addr = {25'h0, dec_addr};
              K_CLR_IO:  next_operand_addr = IO_SHORT_BASE | {25'h0, dec_addr};
              default:   next_operand_addr = operand_addr;
            endcase
            next_cycle_count = is_clr(dec_kind) ? BITC_TOTAL_CYCLES : UNC_TOTAL_CYCLES;
            if ((dec_kind == K_UNC_SHORT) || (dec_kind == K_UNC_REG))
            begin
              next_word_count = ONE_WORD;
              next_state      = S_RUN;
            end
            else
            begin
              next_word_count = TWO_WORDS;
              next_ext_req    = 1'b1;
              next_state      = S_EXT;
            end
          end
        end
      end
      S_EXT:
      begin
        next_ext_req = ~ext_valid;
        if (ext_valid)
        begin
          next_disp    = ext_word;
          // the following instruction sits after the extension word
          next_pc_base = pc_base + 32'h0000_0001;
          if (is_clr(kind))
          begin
            next_operand_req = 1'b1;
            next_state       = S_OPERAND;
          end
          else
            next_state = S_RUN;
        end
      end
      S_OPERAND:
      begin
        next_operand_req = ~operand_ack;
        if (operand_ack)
        begin
          next_tested_bit   = operand_data[bit_sel];
          next_ar_write     = pend_upd;
          next_ar_value     = pend_value;
          next_sp_decrement = pend_pop;
          next_state        = S_RUN;
        end
      end
      S_RUN:
      begin
        if (cnt >= total - 8'h01)
        begin
          next_pc_load      = 1'b1;
          next_branch_taken = is_clr(kind) ? ~tested_bit : 1'b1;
          next_pc_value     = next_branch_taken ? target : pc_base;
          next_busy         = 1'b0;
          next_state        = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state            <= S_IDLE;
      kind             <= K_NONE;
      short_disp       <= 15'h0000;
      disp             <= 32'h0000_0000;
      pc_base          <= 32'h0000_0000;
      reg_disp         <= 32'h0000_0000;
      bit_sel          <= 5'h00;
      tested_bit       <= 1'b0;
      pend_upd         <= 1'b0;
      pend_value       <= 32'h0000_0000;
      pend_pop         <= 1'b0;
      cnt              <= 8'h00;
      busy             <= 1'b0;
      illegal_instr    <= 1'b0;
      ext_req          <= 1'b0;
      operand_req      <= 1'b0;
      operand_is_reg   <= 1'b0;
      operand_space    <= SPACE_FIRST;
      operand_addr     <= 32'h0000_0000;
      operand_reg_code <= 7'h00;
      ar_write         <= 1'b0;
      ar_index         <= 3'h0;
      ar_value         <= 32'h0000_0000;
      sp_decrement     <= 1'b0;
      status_write     <= 1'b0;
      pc_load          <= 1'b0;
      pc_value         <= 32'h0000_0000;
      branch_taken     <= 1'b0;
      cycle_count      <= 8'h00;
      word_count       <= 2'h0;
    end
    else
    begin
      state            <= next_state;
      kind             <= next_kind;
      short_disp       <= next_short_disp;
      disp             <= next_disp;
      pc_base          <= next_pc_base;
      reg_disp         <= next_reg_disp;
      bit_sel          <= next_bit_sel;
      tested_bit       <= next_tested_bit;
      pend_upd         <= next_pend_upd;
      pend_value       <= next_pend_value;
      pend_pop         <= next_pend_pop;
      cnt              <= next_cnt;
      busy             <= next_busy;
      illegal_instr    <= next_illegal_instr;
      ext_req          <= next_ext_req;
      operand_req      <= next_operand_req;
      operand_is_reg   <= next_operand_is_reg;
      operand_space    <= next_operand_space;
      operand_addr     <= next_operand_addr;
      operand_reg_code <= next_operand_reg_code;
      ar_write         <= next_ar_write;
      ar_index         <= next_ar_index;
      ar_value         <= next_ar_value;
      sp_decrement     <= next_sp_decrement;
      status_write     <= 1'b0;
      pc_load          <= next_pc_load;
      pc_value         <= next_pc_value;
      branch_taken     <= next_branch_taken;
      cycle_count      <= next_cycle_count;
      word_count       <= next_word_count;
    end
  end

  a_status_untouched: assert property (@(posedge sys_clk) disable iff (!rst_sync_n) !status_write)
    else $error("status bits written by a branch");
  a_uncond_taken: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pc_load && !is_clr(kind)) |-> (branch_taken && pc_value == pc_base + $past(u_target.disp)))
    else $error("unconditional branch did not jump to pc plus displacement");
  a_clr_on_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pc_load && is_clr(kind)) |-> (branch_taken == !tested_bit))
    else $error("bit-clear branch decision does not match tested bit");
  a_set_falls_through: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pc_load && is_clr(kind) && tested_bit) |-> (pc_value == pc_base))
    else $error("not-taken branch did not continue sequentially");
  a_short_sign_ext: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (state == S_IDLE && instr_valid && dec_kind == K_UNC_SHORT)
    |=> (state == S_RUN && pc_base == $past(instr_pc) + 32'h0000_0001
         && u_target.disp == sext15($past(dec_short))))
    else $error("short branch base or displacement wrong");
  a_uncond_cycles: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pc_load && !is_clr(kind)) |-> ($past(cnt) >= UNC_TOTAL_CYCLES - 8'h01))
    else $error("unconditional branch finished too early");
  a_clr_cycles: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (pc_load && is_clr(kind)) |-> ($past(cnt) >= BITC_TOTAL_CYCLES - 8'h01 && word_count == TWO_WORDS))
    else $error("bit-test branch timing or length wrong");
  a_ext_fetched: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (state == S_IDLE && instr_valid && is_clr(dec_kind)) |=> (ext_req && state == S_EXT))
    else $error("bit-test branch did not request its extension word");
  a_stack_pop: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (state == S_OPERAND && operand_ack) |=> (sp_decrement == $past(pend_pop)))
    else $error("upper stack read did not pop");
  a_ar_update_any: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (state == S_OPERAND && operand_ack && pend_upd) |=> (ar_write && ar_value == $past(pend_value)))
    else $error("address register update skipped");
  a_long_ofs_refused: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (state == S_IDLE && instr_valid && dec_kind == K_NONE) |=> (illegal_instr && !busy))
    else $error("unsupported opcode not refused");

endmodule : relative_branch_exec

// *** relative_branch_exec_tb.sv ***
`timescale 1ns/1ps
module relative_branch_exec_tb;
  import relative_branch_pkg::*;
  logic             sys_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_valid = 1'b0, operand_ack = 1'b0;
  logic [31:0]      instr_word = 32'h0, instr_pc = 32'h0, ext_word = 32'h0, operand_data = 32'h0;
  logic [7:0][31:0] addr_regs, offset_regs;
  logic             busy, illegal_instr, ext_req, operand_req, operand_is_reg, operand_space;
  logic             ar_write, sp_decrement, status_write, pc_load, branch_taken;
  logic             s_sp, s_st, s_reg, s_spc, s_ill, s_ext;
  logic [31:0]      operand_addr, ar_value, pc_value, s_addr;
  logic [35:0]      s_ar;
  logic [6:0]       operand_reg_code, s_code;
  logic [2:0]       ar_index;
  logic [7:0]       cycle_count;
  logic [1:0]       word_count;
  int               mismatches = 0, total_checks = 0, cyc;

  always #5 sys_clk = ~sys_clk;

  relative_branch_exec u_relative_branch_exec (.*);

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // extension and operand answers are held ready, so every wait is the minimum one
  task automatic run(input logic [31:0] op, input logic [31:0] pc, input logic [31:0] ext, input logic [31:0] d);
    @(posedge sys_clk);
    instr_word <= op;
    instr_pc <= pc;
    ext_word <= ext;
    operand_data <= d;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    {s_ar, s_addr, s_sp, s_st, s_reg, s_spc, s_ill, s_ext, s_code} = '0;
    cyc = 0;
    for (int n = 0; n < 40 && cyc == 0; n++)
    begin
      #1;
      if (ar_write === 1'b1) s_ar = {1'b1, ar_index, ar_value};
      if (operand_req === 1'b1) {s_addr, s_reg, s_spc, s_code} = {operand_addr, operand_is_reg, operand_space, operand_reg_code};
      s_sp |= sp_decrement === 1'b1;
      s_ext |= ext_req === 1'b1;
      s_st |= status_write !== 1'b0;
      s_ill |= illegal_instr === 1'b1;
      // cycles counted with the accept cycle as the first one
      if (pc_load === 1'b1) cyc = n + 1;
      @(posedge sys_clk);
    end
    if (cyc == 0 && !s_ill)
    begin
      mismatches++;
      complete_run();
    end
  endtask : run

  task automatic fin(input logic [31:0] pc, input logic tk, input logic [7:0] c, input logic [1:0] w);
    check(pc_value, pc);
    check(branch_taken, tk);
    check({cyc[7:0], cycle_count}, {c, c});
    check(word_count, w);
    check(s_st, 1'b0);
    check(s_ext, w == TWO_WORDS);
    check(busy, 1'b0);
  endtask : fin

  task automatic t_uncond;
    logic [14:0] d;
    d = 15'h4000;
    run({UNC_SHORT_HI, d[14:7], UNC_SHORT_LO, d[6:0]}, 32'h0001_0000, 32'h0, 32'h0);
    fin(32'h0001_0001 + {{17{d[14]}}, d}, 1'b1, 8'h08, 2'h1);
    run(UNC_LONG_WORD, 32'h10, 32'hffff_fff0, 32'h0);
    fin(32'h2, 1'b1, 8'h08, 2'h2);
    run({UNC_REG_HI, 3'h5, UNC_REG_LO}, 32'h20, 32'h0, 32'h0);
    fin(32'h21 + addr_regs[5], 1'b1, 8'h08, 2'h1);
  endtask : t_uncond

  // every indirect mode on r3, odd modes in the second space with the bit set
  task automatic t_clr_ea;
    logic [31:0] r, nn, a;
    logic [35:0] u;
    logic [4:0]  b;
    for (int m = 0; m < 8; m++)
    begin
      r = addr_regs[3];
      nn = offset_regs[3];
      a = (m == 5) ? r + nn : (m == 7) ? r - 32'h1 : r;
      case (m)
        0: u = {4'hb, r - nn};
        1: u = {4'hb, r + nn};
        3: u = {4'hb, r + 32'h1};
        4, 5, 6: u = '0;
        default: u = {4'hb, r - 32'h1};
      endcase
      b = 5'(m * 4 + 3);
      run({8'h02, 4'h8, 3'(m), 3'h3, 5'h02, m[0], 3'h0, b}, 32'h400, 32'h80, m[0] ? 32'h1 << b : ~(32'h1 << b));
      if (m == 6)
        check({s_ill, cyc == 0}, 2'b11);
      else
      begin
        fin(m[0] ? 32'h402 : 32'h482, ~m[0], 8'h0a, 2'h2);
        check({s_addr, s_spc}, {a, m[0]});
        check(s_ar, u);
      end
    end
  endtask : t_clr_ea

  task automatic t_clr_short;
    run({8'h02, 4'ha, 1'b0, 7'h55, 3'h2, 1'b1, 3'h0, 5'h0}, 32'h50, 32'h8, 32'h1);
    fin(32'h52, 1'b0, 8'h0a, 2'h2);
    check({s_addr, s_spc}, {32'h55, 1'b1});
    run({8'h02, 4'ha, 1'b1, 7'h12, 3'h2, 1'b0, 3'h0, 5'h1f}, 32'h60, 32'h8, 32'h7fff_ffff);
    fin(32'h6a, 1'b1, 8'h0a, 2'h2);
    check({s_addr, s_spc}, {32'hffff_ff92, 1'b0});
    run({8'h02, 4'hb, 7'h7c, 1'b0, 4'h4, 3'h0, 5'h4}, 32'h70, 32'hffff_fffe, 32'hffff_ffef);
    fin(32'h70, 1'b1, 8'h0a, 2'h2);
    check({s_reg, s_code, s_sp}, {1'b1, 7'h7c, 1'b1});
  endtask : t_clr_short

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      addr_regs[i] = 32'hffff_ff00 + 32'h11 * i;
      offset_regs[i] = 32'h10 + i;
    end
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    ext_valid <= 1'b1;
    operand_ack <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_uncond();
    t_clr_ea();
    t_clr_short();
    complete_run();
  end
endmodule : relative_branch_exec_tb
